// ### flash_status_register_one_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_register_one_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
    logic [1:0] pins;
    logic [1:0] resp;
    logic [7:0] st;
    logic [1:0] ev;
  } fsr_row_t;

  // pins: {wp_n, target_protected}; resp: 1 done, 2 fail, 3 pause on suspend; ev: {suspend, req}
  localparam int NROW = 35;
  localparam fsr_row_t ROWS [NROW] = '{
    '{8'h01, 8'hff, 2'h2, 2'h0, 8'h00, 2'h0}, '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0},
    '{8'h04, 8'h00, 2'h2, 2'h0, 8'h00, 2'h0}, '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0},
    '{8'h01, 8'hff, 2'h2, 2'h0, 8'h9c, 2'h0}, '{8'h06, 8'h00, 2'h2, 2'h0, 8'h9e, 2'h0},
    '{8'h01, 8'h00, 2'h0, 2'h0, 8'h9e, 2'h0}, '{8'h01, 8'h00, 2'h2, 2'h0, 8'h00, 2'h0},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'ha1, 8'h00, 2'h2, 2'h1, 8'h00, 2'h1},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'ha2, 8'h00, 2'h2, 2'h2, 8'h23, 2'h1},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h23, 2'h0}, '{8'h05, 8'h00, 2'h2, 2'h0, 8'h23, 2'h0},
    '{8'h30, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'h04, 8'h00, 2'h2, 2'h0, 8'h00, 2'h0},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'ha1, 8'h00, 2'h3, 2'h0, 8'h43, 2'h0},
    '{8'h30, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'ha2, 8'h00, 2'h3, 2'h0, 8'h23, 2'h0},
    '{8'h30, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'ha3, 8'h00, 2'h3, 2'h1, 8'h00, 2'h1},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0}, '{8'h01, 8'h04, 2'h2, 2'h0, 8'h04, 2'h0},
    '{8'h06, 8'h00, 2'h2, 2'h0, 8'h06, 2'h0}, '{8'ha3, 8'h00, 2'h2, 2'h1, 8'h06, 2'h0},
    '{8'h01, 8'h00, 2'h2, 2'h0, 8'h00, 2'h0}, '{8'h06, 8'h00, 2'h2, 2'h0, 8'h02, 2'h0},
    '{8'ha1, 8'h00, 2'h2, 2'h0, 8'h03, 2'h1}, '{8'ha4, 8'h00, 2'h2, 2'h0, 8'h03, 2'h0},
    '{8'ha5, 8'h00, 2'h2, 2'h3, 8'h02, 2'h2}, '{8'ha2, 8'h00, 2'h2, 2'h0, 8'h03, 2'h1},
    '{8'ha4, 8'h00, 2'h2, 2'h3, 8'h02, 2'h2}, '{8'ha1, 8'h00, 2'h2, 2'h2, 8'h43, 2'h1},
    '{8'ha6, 8'h00, 2'h2, 2'h0, 8'h00, 2'h0}
  };

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  wire sck;
  wire cs_n;
  wire mosi;
  logic miso;
  logic miso_oe;
  logic wp_n = 1'b1;
  logic hw_reset_n = 1'b1;
  logic protect_volatility_sel = 1'b0;
  logic target_protected = 1'b0;
  logic core_done = 1'b0;
  logic core_fail = 1'b0;
  logic core_paused = 1'b0;
  fsr_pkg::fsr_core_req_t core_req;
  logic core_suspend;
  fsr_pkg::fsr_status_t status_byte_one;
  logic [1:0] resp = 2'h0;
  logic [3:0] rsp_dly = 4'h0;
  logic [1:0] last_kind = 2'h0;
  int req_cnt = 0;
  int sus_cnt = 0;
  int failures = 0;
  int cmp_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  fsr_status_reg fsr_status_reg_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n), .hw_reset_n(hw_reset_n),
    .protect_volatility_sel(protect_volatility_sel), .target_protected(target_protected),
    .core_done(core_done), .core_fail(core_fail), .core_paused(core_paused),
    .core_req(core_req), .core_suspend(core_suspend), .status_byte_one(status_byte_one)
  );

  fsr_spi_host fsr_spi_host_inst (
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );

  // array core stand-in: answers four cycles after a start or a suspend
  always @(posedge sys_clk) begin
    core_done <= 1'b0;
    core_fail <= 1'b0;
    core_paused <= 1'b0;
    if (core_req.valid || core_suspend) begin
      rsp_dly <= 4'h4;
    end else if (rsp_dly != 4'h0) begin
      rsp_dly <= rsp_dly - 4'h1;
    end
    if (rsp_dly == 4'h1) begin
      core_done <= (resp == 2'h1);
      core_fail <= (resp == 2'h2);
      core_paused <= (resp == 2'h3);
    end
    if (core_req.valid) begin
      req_cnt <= req_cnt + 1;
      last_kind <= core_req.kind;
    end
    if (core_suspend) begin
      sus_cnt <= sus_cnt + 1;
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // status lands 5-6 cycles after deselect; only the busy bit is waited on, so the
  // full byte is still compared by the caller and a wrong value cannot slip through
  task automatic wait_status(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    while (status_byte_one.busy !== exp[0] && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      failures++;
      $display("[ERR] %0t status wait timed out", $time);
      end_of_test();
    end
  endtask

  initial begin
    logic [7:0] rd;
    int r0;
    int s0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < NROW; i++) begin
      @(posedge sys_clk);
      wp_n <= ROWS[i].pins[1];
      target_protected <= ROWS[i].pins[0];
      resp <= ROWS[i].resp;
      r0 = req_cnt;
      s0 = sus_cnt;
      fsr_spi_host_inst.xfer(ROWS[i].op, ROWS[i].data, rd);
      wait_status(ROWS[i].st);
      check(status_byte_one, ROWS[i].st, "status");
      if (ROWS[i].op == fsr_pkg::OP_STATUS_READ) begin
        check(rd, ROWS[i].st, "read data");
      end
      check({4'(sus_cnt - s0), 4'(req_cnt - r0)}, {3'h0, ROWS[i].ev[1], 3'h0, ROWS[i].ev[0]},
        "core events");
      if (ROWS[i].ev[0]) begin
        check({6'h00, last_kind}, {6'h00, 2'(ROWS[i].op - 8'ha1)}, "core kind");
      end
      $display("row %0d done", i);
    end
    // volatile protection: a full reset loads all-ones protection bits
    @(posedge sys_clk);
    rst <= 1'b1;
    protect_volatility_sel <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check(status_byte_one, 8'h1c, "volatile reset");
    $display("volatile reset test done");
    fsr_spi_host_inst.xfer(fsr_pkg::OP_WRITE_ENABLE, 8'h00, rd);
    wait_status(8'h1e);
    check(status_byte_one, 8'h1e, "latch set");
    @(posedge sys_clk);
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    hw_reset_n <= 1'b1;
    wait_status(8'h1c);
    check(status_byte_one, 8'h1c, "pin reset");
    fsr_spi_host_inst.xfer(fsr_pkg::OP_STATUS_READ, 8'h00, rd);
    check(rd, 8'h1c, "read after pin reset");
    $display("pin reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### fsr_pkg.sv
package fsr_pkg;

  // serial opcodes served by the status byte
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_REG_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;

  // status byte reset values
  localparam logic [2:0] BP_VOLATILE_DEFAULT = 3'h7;
  localparam logic [2:0] BP_SHIPPED_DEFAULT = 3'h0;

  // frame byte counts
  localparam logic [1:0] NBYTES_NONE = 2'h0;
  localparam logic [1:0] NBYTES_OP = 2'h1;
  localparam logic [1:0] NBYTES_DATA = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // synchroniser idle levels: cs_n, wp_n, hw_reset_n high, frame toggle low
  localparam logic [3:0] SYNC_IDLE = 4'h e;

  // internal register write time
  localparam int SYS_PERIOD_PS = 5000;
  localparam int WREG_TIME_NS = 50;
  localparam int WREG_CYC_INT = (WREG_TIME_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [7:0] WREG_LAST = 8'(WREG_CYC_INT - 1);

  typedef struct packed {
    logic lock;
    logic prog_err;
    logic erase_err;
    logic [2:0] bp;
    logic write_enable_latch;
    logic busy;
  } fsr_status_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
    logic [1:0] nbytes;
  } fsr_frame_t;

  typedef enum logic [2:0] {
    RUN_IDLE,
    RUN_WREG,
    RUN_PROG,
    RUN_SERASE,
    RUN_BERASE
  } fsr_run_t;

  typedef enum logic [1:0] {
    KIND_PROG,
    KIND_SERASE,
    KIND_BERASE
  } fsr_kind_t;

  typedef struct packed {
    logic valid;
    fsr_kind_t kind;
  } fsr_core_req_t;

endpackage

// ### fsr_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
// serial host on the far side of the status byte; mode 0, sck idles low between frames
module fsr_spi_host (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame: opcode, then the data byte for register writes, or eight read clocks
  task automatic xfer(input logic [7:0] op, input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] sh;
    int nbits;
    sh = {op, data};
    nbits = (op == fsr_pkg::OP_STATUS_READ || op == fsr_pkg::OP_REG_WRITE) ? 16 : 8;
    rd = 8'h00;
    #7 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = sh[15 - i];
      #15 sck = 1'b1;
      // a released miso line must not pass for data
      if (i >= 8) rd = {rd[6:0], miso_oe ? miso : 1'bx};
      #15 sck = 1'b0;
    end
    #15 cs_n = 1'b1;
    mosi = ~mosi;
    // deselect time well above the 30 ns minimum
    #60;
  endtask
endmodule
`default_nettype wire

// ### fsr_status_reg.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - 05h reads status, 01h writes it
// - lock plus low wp_n freezes lock/bp, refuses write
// - high wp_n or clear lock allows write
// - program failure or protected target sets program error
// - erase failure or protected sector sets erase error
// - whole-array erase never flags protected sectors
// - clear-status, soft reset and resets clear errors; write keeps them
// - protected range rejects program and sector erase
// - bp volatility follows config select input
// - whole-array erase only with bp all zero
// - write-enable command sets latch
// - write-disable command clears latch
// - latch low ignores write, program, erase
// - successful operation end clears latch
// - resets clear latch; register write clears it when the write ends
// - busy set while any operation runs
// - busy admits only reads, suspends, clear, reset
// - suspend accepted only for matching operation
// - error flags update during busy operation
// - error holds busy until clear-status or a reset
// - resets restore volatile bits; pin and soft resets keep non-volatile
module fsr_status_reg #(
  parameter logic [7:0] OP_PROGRAM = 8'h a1,
  parameter logic [7:0] OP_SECTOR_ERASE = 8'h a2,
  parameter logic [7:0] OP_WHOLE_ERASE = 8'h a3,
  parameter logic [7:0] OP_ERASE_SUSPEND = 8'h a4,
  parameter logic [7:0] OP_PROGRAM_SUSPEND = 8'h a5,
  parameter logic [7:0] OP_SOFT_RESET = 8'h a6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic wp_n,
  input wire logic hw_reset_n,
  input wire logic protect_volatility_sel,
  input wire logic target_protected,
  input wire logic core_done,
  input wire logic core_fail,
  input wire logic core_paused,
  output fsr_pkg::fsr_core_req_t core_req,
  output logic core_suspend,
  output fsr_pkg::fsr_status_t status_byte_one
);

  // ---------------- serial clock domain ----------------
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [6:0] shift_reg;
  fsr_pkg::fsr_frame_t frame_reg;
  logic frame_tog_reg;
  logic miso_reg;
  logic miso_oe_reg;
  fsr_pkg::fsr_status_t shadow_reg;

  // frame position, cleared by the frame's own chip select
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= fsr_pkg::NBYTES_NONE;
      shift_reg <= 7'h0;
    end else begin
      shift_reg <= {shift_reg[5:0], mosi};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == fsr_pkg::LAST_BIT && byte_cnt_reg != fsr_pkg::NBYTES_DATA) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
    end
  end

  // completed bytes stay put after the frame so the system side can read them
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      frame_reg <= '0;
      frame_tog_reg <= 1'b0;
    end else if (!cs_n && bit_cnt_reg == fsr_pkg::LAST_BIT) begin
      if (byte_cnt_reg == fsr_pkg::NBYTES_NONE) begin
        frame_reg.op <= {shift_reg, mosi};
        frame_reg.nbytes <= fsr_pkg::NBYTES_OP;
        frame_tog_reg <= ~frame_tog_reg;
      end else if (byte_cnt_reg == fsr_pkg::NBYTES_OP) begin
        frame_reg.data <= {shift_reg, mosi};
        frame_reg.nbytes <= fsr_pkg::NBYTES_DATA;
      end
    end
  end

  // status read-out; shadow is frozen by the system side for the whole frame
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= byte_cnt_reg != fsr_pkg::NBYTES_NONE
                     && frame_reg.op == fsr_pkg::OP_STATUS_READ;
      miso_reg <= shadow_reg[~bit_cnt_reg];
    end
  end

  assign miso = miso_reg;
  assign miso_oe = miso_oe_reg;

  // ---------------- system clock domain ----------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] filt_reg;
  logic cs_prev_reg;
  logic tog_seen_reg;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= fsr_pkg::SYNC_IDLE;
      sync2_reg <= fsr_pkg::SYNC_IDLE;
      sync3_reg <= fsr_pkg::SYNC_IDLE;
      filt_reg <= fsr_pkg::SYNC_IDLE;
    end else if (ce) begin
      sync1_reg <= {cs_n, wp_n, hw_reset_n, frame_tog_reg};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  logic cs_q;
  logic wp_q;
  logic hw_rst_act;
  logic tog_q;
  logic frame_evt;
  assign cs_q = filt_reg[3];
  assign wp_q = filt_reg[2];
  assign hw_rst_act = !filt_reg[1];
  assign tog_q = filt_reg[0];
  // a frame counts only if it carried at least one whole byte
  assign frame_evt = cs_q && !cs_prev_reg && (tog_q != tog_seen_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else if (ce) begin
      cs_prev_reg <= cs_q;
      if (frame_evt) begin
        tog_seen_reg <= tog_q;
      end
    end
  end

  logic lock_reg;
  logic perr_reg;
  logic eerr_reg;
  logic [2:0] bp_reg;
  logic wel_reg;
  fsr_pkg::fsr_run_t run_reg;
  logic [7:0] tmr_reg;
  fsr_pkg::fsr_status_t status_now;
  fsr_pkg::fsr_status_t wr_data;

  logic busy;
  logic locked;
  logic vol_rst;
  logic idle_ok;
  logic c_write_enable_cmd, c_write_disable_cmd, c_clear_status_cmd, c_wreg, c_prog, c_serase, c_berase;
  logic c_esusp, c_psusp;
  logic core_run;
  logic ok_end;
  logic prog_set, erase_set;

  assign busy = run_reg != fsr_pkg::RUN_IDLE || perr_reg || eerr_reg;
  assign locked = lock_reg && !wp_q;
  assign vol_rst = hw_rst_act || (frame_evt && frame_reg.op == OP_SOFT_RESET);
  assign idle_ok = frame_evt && !busy;
  assign wr_data = fsr_pkg::fsr_status_t'(frame_reg.data);
  assign c_write_enable_cmd = idle_ok && frame_reg.op == fsr_pkg::OP_WRITE_ENABLE;
  assign c_write_disable_cmd = idle_ok && frame_reg.op == fsr_pkg::OP_WRITE_DISABLE;
  assign c_clear_status_cmd = frame_evt && frame_reg.op == fsr_pkg::OP_CLEAR_STATUS;
  assign c_wreg = idle_ok && frame_reg.op == fsr_pkg::OP_REG_WRITE && wel_reg && !locked
                  && frame_reg.nbytes == fsr_pkg::NBYTES_DATA;
  assign c_prog = idle_ok && frame_reg.op == OP_PROGRAM && wel_reg;
  assign c_serase = idle_ok && frame_reg.op == OP_SECTOR_ERASE && wel_reg;
  assign c_berase = idle_ok && frame_reg.op == OP_WHOLE_ERASE && wel_reg
                    && bp_reg == 3'h0;
  assign c_esusp = frame_evt && frame_reg.op == OP_ERASE_SUSPEND
                   && (run_reg == fsr_pkg::RUN_SERASE || run_reg == fsr_pkg::RUN_BERASE);
  assign c_psusp = frame_evt && frame_reg.op == OP_PROGRAM_SUSPEND
                   && run_reg == fsr_pkg::RUN_PROG;
  assign core_run = run_reg == fsr_pkg::RUN_PROG || run_reg == fsr_pkg::RUN_SERASE
                    || run_reg == fsr_pkg::RUN_BERASE;
  assign ok_end = (run_reg == fsr_pkg::RUN_WREG && tmr_reg == fsr_pkg::WREG_LAST)
                  || (core_run && core_done && !core_fail);
  // protected range is resolved by the array core from the bp bits we export
  assign prog_set = (c_prog && target_protected)
                    || (run_reg == fsr_pkg::RUN_PROG && core_fail);
  // a whole-array erase never flags protected sectors, only real failures
  assign erase_set = (c_serase && target_protected)
                     || ((run_reg == fsr_pkg::RUN_SERASE || run_reg == fsr_pkg::RUN_BERASE)
                     && core_fail);

  // write-enable latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wel_reg <= 1'b0;
    end else if (ce) begin
      if (vol_rst) begin
        wel_reg <= 1'b0;
      end else if (c_write_enable_cmd) begin
        wel_reg <= 1'b1;
      end else if (c_write_disable_cmd || ok_end) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // error flags: a new error wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      perr_reg <= 1'b0;
      eerr_reg <= 1'b0;
    end else if (ce) begin
      if (vol_rst) begin
        perr_reg <= 1'b0;
        eerr_reg <= 1'b0;
      end else begin
        perr_reg <= prog_set || (perr_reg && !c_clear_status_cmd);
        eerr_reg <= erase_set || (eerr_reg && !c_clear_status_cmd);
      end
    end
  end

  // protection bits; volatile bp return to all ones on any reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
      bp_reg <= protect_volatility_sel ? fsr_pkg::BP_VOLATILE_DEFAULT
                                       : fsr_pkg::BP_SHIPPED_DEFAULT;
    end else if (ce) begin
      if (vol_rst) begin
        if (protect_volatility_sel) begin
          bp_reg <= fsr_pkg::BP_VOLATILE_DEFAULT;
        end
      end else if (c_wreg) begin
        lock_reg <= wr_data.lock;
        bp_reg <= wr_data.bp;
      end
    end
  end

  // operation sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_reg <= fsr_pkg::RUN_IDLE;
      tmr_reg <= 8'h0;
    end else if (ce) begin
      if (vol_rst) begin
        run_reg <= fsr_pkg::RUN_IDLE;
      end else begin
        case (run_reg)
          fsr_pkg::RUN_IDLE: begin
            tmr_reg <= 8'h0;
            if (c_wreg) begin
              run_reg <= fsr_pkg::RUN_WREG;
            end else if (c_prog && !target_protected) begin
              run_reg <= fsr_pkg::RUN_PROG;
            end else if (c_serase && !target_protected) begin
              run_reg <= fsr_pkg::RUN_SERASE;
            end else if (c_berase) begin
              run_reg <= fsr_pkg::RUN_BERASE;
            end
          end
          fsr_pkg::RUN_WREG: begin
            tmr_reg <= tmr_reg + 8'h1;
            if (tmr_reg == fsr_pkg::WREG_LAST) begin
              run_reg <= fsr_pkg::RUN_IDLE;
            end
          end
          default: begin
            if (core_done || core_fail || core_paused) begin
              run_reg <= fsr_pkg::RUN_IDLE;
            end
          end
        endcase
      end
    end
  end

  // requests to the array core, one-cycle pulses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_req <= '0;
      core_suspend <= 1'b0;
    end else if (ce) begin
      core_req.valid <= !vol_rst && ((c_prog && !target_protected)
                        || (c_serase && !target_protected) || c_berase);
      core_req.kind <= c_berase ? fsr_pkg::KIND_BERASE
                     : (c_serase ? fsr_pkg::KIND_SERASE : fsr_pkg::KIND_PROG);
      core_suspend <= !vol_rst && (c_esusp || c_psusp);
    end
  end

  always_comb begin
    status_now = '0;
    status_now.lock = lock_reg;
    status_now.prog_err = perr_reg;
    status_now.erase_err = eerr_reg;
    status_now.bp = bp_reg;
    status_now.write_enable_latch = wel_reg;
    status_now.busy = busy;
  end

  // shadow only moves between frames, so the serial side sees a steady byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow_reg <= '0;
      status_byte_one <= '0;
    end else if (ce) begin
      status_byte_one <= status_now;
      if (cs_q) begin
        shadow_reg <= status_now;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  property p_write_enable_cmd;
    c_write_enable_cmd && !hw_rst_act |=> wel_reg;
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("write enable did not set latch");

  property p_write_disable_cmd;
    c_write_disable_cmd && !hw_rst_act |=> !wel_reg;
  endproperty
  a_write_disable_cmd: assert property (p_write_disable_cmd) else $error("write disable did not clear latch");

  property p_locked;
    frame_evt && frame_reg.op == fsr_pkg::OP_REG_WRITE && locked && !hw_rst_act
      |=> $stable(lock_reg) && $stable(bp_reg) && run_reg == fsr_pkg::RUN_IDLE;
  endproperty
  a_locked: assert property (p_locked) else $error("locked register write was taken");

  property p_wreg_time;
    c_wreg && !hw_rst_act |=> (busy && wel_reg) ##9 (busy && wel_reg) ##1 (!wel_reg && !busy);
  endproperty
  a_wreg_time: assert property (p_wreg_time) else $error("register write timing wrong");

  // the latch must survive the whole internal write, not only its two ends
  property p_wreg_hold;
    run_reg == fsr_pkg::RUN_WREG |-> wel_reg && busy;
  endproperty
  a_wreg_hold: assert property (p_wreg_hold) else $error("latch lost during register write");

  property p_clear_status_cmd;
    c_clear_status_cmd && !prog_set && !erase_set |=> !perr_reg && !eerr_reg;
  endproperty
  a_clear_status_cmd: assert property (p_clear_status_cmd) else $error("clear status left an error");

  // checked at the port and on the request path, not on the busy expression itself
  property p_err_busy;
    perr_reg || eerr_reg |=> status_byte_one.busy && !core_req.valid;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("error without busy");

  property p_prog_prot;
    c_prog && target_protected && !hw_rst_act |=> perr_reg && !core_req.valid;
  endproperty
  a_prog_prot: assert property (p_prog_prot) else $error("protected program not flagged");

  property p_whole_bp;
    frame_evt && frame_reg.op == OP_WHOLE_ERASE && bp_reg != 3'h0 |=> !core_req.valid;
  endproperty
  a_whole_bp: assert property (p_whole_bp) else $error("whole erase ran under protection");

  property p_req_gate;
    core_req.valid |-> $past(wel_reg) && !$past(busy);
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request without latch or while busy");

  property p_susp;
    core_suspend |-> $past(core_run);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend with no matching operation");

  c_wreg_done: cover property (c_wreg ##11 !busy);
  c_err_clear: cover property (perr_reg ##[1:20] !busy);
  c_core_op: cover property (core_req.valid ##[1:50] core_done);

endmodule
`default_nettype wire
